// file: ovc_cfg.svh
`ifndef OVC_CFG_SVH
`define OVC_CFG_SVH

// Command codes
`define OVC_CODE_FORMAT 8'h20
`define OVC_CODE_TARGET 8'h21
`define OVC_CODE_OFFSET 8'h22

// Format byte fields
`define OVC_REL_BIT 7
`define OVC_MODE_MSB 6
`define OVC_MODE_LSB 5
`define OVC_EXP_MSB 4
`define OVC_MODE_LINEAR 2'h0

// Supported exponent range, two's complement, 5 bits
`define OVC_EXP_LOW 5'h14
`define OVC_EXP_HIGH 5'h1c

// Reset values held until the defaults are loaded
`define OVC_FORMAT_RST 8'h14
`define OVC_WORD_RST 16'h0000

// Offset backup: 8 bits at exponent -12, limited to +127 / -128
`define OVC_BACKUP_EXP 5'h14
`define OVC_BACKUP_MAX 16'sh007f
`define OVC_BACKUP_MIN -16'sh0080

// Ramp timing
`define OVC_CLK_NS 20
`define OVC_RAMP_TICK_NS 1000
`define OVC_RAMP_TICK_CYC ((`OVC_RAMP_TICK_NS + `OVC_CLK_NS - 1) / `OVC_CLK_NS)

`endif

// file: ovc_pkg.sv
package ovc_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } ovc_cmd_s;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [15:0] rdata;
  } ovc_rsp_s;

  typedef struct packed {
    logic limit_warn;
    logic word_vout;
    logic byte_none_above;
  } ovc_stat_s;

  typedef struct packed {
    logic [7:0] format;
    logic [15:0] target;
    logic [7:0] offset_backup;
    logic [15:0] pin_target;
  } ovc_dflt_s;

  typedef struct packed {
    logic default_source_select;
    logic fault_target_reload;
    logic reset_pin_mode;
  } ovc_misc_s;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
  } ovc_limit_s;

endpackage

// file: ovc_rescale.sv
`timescale 1ns/100ps
// Rescales a linear mantissa from one exponent to another
module ovc_rescale (
  input wire logic [15:0] value,
  input wire logic is_signed,
  input wire logic [4:0] from_exp,
  input wire logic [4:0] to_exp,
  output logic [15:0] result
);
  logic signed [5:0] diff;
  logic [5:0] mag;
  always_comb begin
    diff = $signed({from_exp[4], from_exp}) - $signed({to_exp[4], to_exp});
    mag = diff[5] ? 6'(-diff) : 6'(diff);
    if (!diff[5]) begin
      result = value << mag[3:0];
    end else if (is_signed) begin
      result = 16'($signed(value) >>> mag[3:0]);
    end else begin
      result = value >> mag[3:0];
    end
  end
endmodule

// file: ovc_ramp.sv
`timescale 1ns/100ps
`include "ovc_cfg.svh"
// Walks the level toward the goal by one step each ramp tick
module ovc_ramp (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] goal,
  input wire logic [15:0] step,
  input wire logic jump,
  output logic [15:0] level
);
  typedef struct packed {
    logic [15:0] level;
    logic [15:0] cnt;
  } ovc_ramp_s;
  ovc_ramp_s s;
  ovc_ramp_s next_s;
  logic tick;
  always_comb begin
    next_s = s;
    tick = (s.cnt == 16'(`OVC_RAMP_TICK_CYC - 1));
    next_s.cnt = tick ? 16'h0000 : s.cnt + 16'h0001;
    // Scale changed or zero rate: no ramp, step at once
    if (jump || step == 16'h0000) begin
      next_s.level = goal;
    end else if (tick) begin
      if (goal > s.level) begin
        next_s.level = (goal - s.level > step) ? s.level + step : goal;
      end else begin
        next_s.level = (s.level - goal > step) ? s.level - step : goal;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign level = s.level;
endmodule

// file: ovc_regs.sv
`timescale 1ns/100ps
`include "ovc_cfg.svh"
module ovc_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire ovc_pkg::ovc_cmd_s cmd,
  output ovc_pkg::ovc_rsp_s rsp,
  input wire logic conversion_enable_pin,
  input wire logic power_good_or_reset_pin_n,
  input wire ovc_pkg::ovc_misc_s miscellaneous_settings,
  input wire ovc_pkg::ovc_dflt_s defaults,
  input wire ovc_pkg::ovc_limit_s limits,
  input wire logic [15:0] transition_step,
  input wire logic restore_all,
  input wire logic fault_restart,
  input wire logic status_clear,
  output ovc_pkg::ovc_stat_s status,
  output logic limit_alert,
  output logic [7:0] offset_backup,
  output logic [15:0] reference
);
  typedef struct packed {
    logic en_meta;
    logic en_sync;
    logic rst_meta;
    logic rst_sync;
    logic init_pend;
    logic chk_pend;
    logic rescale;
    logic [7:0] format;
    logic [15:0] target;
    logic [15:0] offset;
    logic [15:0] boot;
    logic [7:0] backup;
    logic alert;
    ovc_pkg::ovc_rsp_s rsp;
    ovc_pkg::ovc_stat_s stat;
  } ovc_regs_s;

  ovc_regs_s s;
  ovc_regs_s next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Exponent handling

  logic [4:0] cur_exp;
  logic [4:0] wr_exp;
  logic [4:0] nvm_exp;
  logic [4:0] new_exp;
  logic wr_exp_ok;
  logic load_dflt;
  logic fmt_write;
  logic [15:0] tgt_conv;
  logic [15:0] off_conv;
  logic [15:0] boot_conv;
  logic [15:0] dflt_conv;
  logic [15:0] bak_conv;
  logic [15:0] off_at_bak;
  logic [15:0] dflt_pick;
  logic busy;
  logic pin_hold;
  logic fault_load;
  logic fmt_take;
  logic clamp_hit;

  assign cur_exp = s.format[`OVC_EXP_MSB:0];
  assign wr_exp = cmd.wdata[`OVC_EXP_MSB:0];
  assign nvm_exp = defaults.format[`OVC_EXP_MSB:0];
  assign wr_exp_ok = ($signed(wr_exp) >= $signed(`OVC_EXP_LOW))
                     && ($signed(wr_exp) <= $signed(`OVC_EXP_HIGH));
  assign load_dflt = s.init_pend || restore_all;
  assign fmt_write = cmd.valid && cmd.write && cmd.code == `OVC_CODE_FORMAT;
  assign dflt_pick = miscellaneous_settings.default_source_select
                     ? defaults.pin_target : defaults.target;
  assign pin_hold = miscellaneous_settings.reset_pin_mode && !s.rst_sync;
  assign fault_load = fault_restart && miscellaneous_settings.fault_target_reload;
  // Only a format write that will be taken may steer the rescalers
  assign fmt_take = fmt_write && wr_exp_ok && !s.en_sync
                    && !pin_hold && !fault_load;

  always_comb begin
    if (load_dflt) begin
      new_exp = nvm_exp;
    end else if (fmt_take) begin
      new_exp = wr_exp;
    end else begin
      new_exp = cur_exp;
    end
  end

  // Stored words rescaled to the exponent about to take effect
  ovc_rescale u_tgt (
    .value(s.target),
    .is_signed(1'b0),
    .from_exp(cur_exp),
    .to_exp(new_exp),
    .result(tgt_conv)
  );

  ovc_rescale u_off (
    .value(s.offset),
    .is_signed(1'b1),
    .from_exp(cur_exp),
    .to_exp(new_exp),
    .result(off_conv)
  );

  ovc_rescale u_boot (
    .value(s.boot),
    .is_signed(1'b0),
    .from_exp(cur_exp),
    .to_exp(new_exp),
    .result(boot_conv)
  );

  // Defaults and backup brought to the exponent in force
  ovc_rescale u_dflt (
    .value(dflt_pick),
    .is_signed(1'b0),
    .from_exp(nvm_exp),
    .to_exp(new_exp),
    .result(dflt_conv)
  );

  ovc_rescale u_bak (
    .value({{8{defaults.offset_backup[7]}}, defaults.offset_backup}),
    .is_signed(1'b1),
    .from_exp(`OVC_BACKUP_EXP),
    .to_exp(new_exp),
    .result(bak_conv)
  );

  // Offset as seen at the backup exponent
  ovc_rescale u_out (
    .value(s.offset),
    .is_signed(1'b1),
    .from_exp(cur_exp),
    .to_exp(`OVC_BACKUP_EXP),
    .result(off_at_bak)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reference goal with limit clamp

  logic signed [17:0] sum;
  logic over;
  logic under;
  logic [15:0] goal;

  always_comb begin
    sum = $signed({2'b00, s.target}) + $signed({{2{s.offset[15]}}, s.offset});
    over = sum > $signed({2'b00, limits.upper});
    under = sum < $signed({2'b00, limits.lower});
    if (over) begin
      goal = limits.upper;
    end else if (under) begin
      goal = limits.lower;
    end else begin
      goal = sum[15:0];
    end
  end

  // Clamp seen in the cycle after a target or offset write or a default load
  assign clamp_hit = s.chk_pend && (over || under);

  ////////////////////////////////////////////////////////////////////////////
  // Command handling and state update

  always_comb begin
    next_s = s;
    next_s.en_meta = conversion_enable_pin;
    next_s.en_sync = s.en_meta;
    next_s.rst_meta = power_good_or_reset_pin_n;
    next_s.rst_sync = s.rst_meta;
    next_s.rescale = 1'b0;
    next_s.chk_pend = 1'b0;
    next_s.rsp = '0;
    busy = 1'b1;
    if (load_dflt) begin
      next_s.init_pend = 1'b0;
      next_s.format = {defaults.format[`OVC_REL_BIT], `OVC_MODE_LINEAR, nvm_exp};
      next_s.boot = dflt_pick;
      next_s.target = dflt_pick;
      next_s.offset = bak_conv;
      next_s.rescale = 1'b1;
      next_s.chk_pend = 1'b1;
    end else if (pin_hold) begin
      next_s.target = s.boot;
    end else if (fault_load) begin
      next_s.target = dflt_conv;
    end else begin
      busy = 1'b0;
    end
    if (cmd.valid) begin
      next_s.rsp.valid = 1'b1;
      next_s.rsp.ack = !busy;
      unique case (cmd.code)
        `OVC_CODE_FORMAT: begin
          next_s.rsp.rdata = {8'h00, s.format};
          if (cmd.write) begin
            if (busy || s.en_sync || !wr_exp_ok) begin
              next_s.rsp.ack = 1'b0;
            end else begin
              next_s.format = {cmd.wdata[`OVC_REL_BIT], `OVC_MODE_LINEAR, wr_exp};
              next_s.target = tgt_conv;
              next_s.offset = off_conv;
              next_s.boot = boot_conv;
              next_s.rescale = 1'b1;
            end
          end
        end
        `OVC_CODE_TARGET: begin
          next_s.rsp.rdata = s.target;
          if (cmd.write && !busy) begin
            next_s.target = cmd.wdata;
            next_s.chk_pend = 1'b1;
          end
        end
        `OVC_CODE_OFFSET: begin
          next_s.rsp.rdata = s.offset;
          if (cmd.write && !busy) begin
            next_s.offset = cmd.wdata;
            next_s.chk_pend = 1'b1;
          end
        end
        default: begin
          next_s.rsp.ack = 1'b0;
        end
      endcase
    end
    // Backup image of the offset, saturated to the 8-bit range
    if ($signed(off_at_bak) > `OVC_BACKUP_MAX) begin
      next_s.backup = 8'h7f;
    end else if ($signed(off_at_bak) < `OVC_BACKUP_MIN) begin
      next_s.backup = 8'h80;
    end else begin
      next_s.backup = off_at_bak[7:0];
    end
    // Warning flags: a new warning wins over a clear in the same cycle
    if (status_clear) begin
      next_s.stat = '0;
      next_s.alert = 1'b0;
    end
    if (clamp_hit) begin
      next_s.stat.limit_warn = 1'b1;
      next_s.stat.word_vout = 1'b1;
      next_s.stat.byte_none_above = 1'b1;
      next_s.alert = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.rst_meta <= 1'b1;
      s.rst_sync <= 1'b1;
      s.init_pend <= 1'b1;
      s.format <= `OVC_FORMAT_RST;
      s.target <= `OVC_WORD_RST;
      s.offset <= `OVC_WORD_RST;
      s.boot <= `OVC_WORD_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramped reference

  ovc_ramp u_ramp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .goal(goal),
    .step(transition_step),
    .jump(s.rescale),
    .level(reference)
  );

  assign rsp = s.rsp;
  assign status = s.stat;
  assign limit_alert = s.alert;
  assign offset_backup = s.backup;
endmodule

// file: ovc_host.sv
`timescale 1ns/100ps
// Host side: one command per call, answer taken while it stands
module ovc_host (
  input wire logic sys_clk,
  output ovc_pkg::ovc_cmd_s cmd,
  input wire ovc_pkg::ovc_rsp_s rsp
);
  logic [15:0] rd;
  logic ack;
  initial cmd = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(negedge sys_clk);
    cmd <= {1'b1, w, c, d};
    @(negedge sys_clk);
    // Released fields show the inverse, never the old value
    cmd <= {2'b00, ~c, ~d};
    ack = rsp.valid & rsp.ack;
    rd = rsp.rdata;
  endtask
endmodule

// file: ovc_regs_asserts.sv
`timescale 1ns/100ps
`include "ovc_cfg.svh"
module ovc_regs_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire ovc_pkg::ovc_cmd_s cmd,
  input wire ovc_pkg::ovc_rsp_s rsp,
  input wire logic conversion_enable_pin,
  input wire ovc_pkg::ovc_stat_s status,
  input wire logic limit_alert
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic fmt_wr;
  logic bad_code;
  logic bad_exp;
  assign fmt_wr = cmd.valid && cmd.write && cmd.code == `OVC_CODE_FORMAT;
  assign bad_code = cmd.code < `OVC_CODE_FORMAT || cmd.code > `OVC_CODE_OFFSET;
  assign bad_exp = cmd.wdata[4:0] < `OVC_EXP_LOW || cmd.wdata[4:0] > `OVC_EXP_HIGH;
  chk_rsp_one_cycle: assert property (cmd.valid |=> rsp.valid)
    else $error("no answer one cycle after command");
  chk_rsp_no_cmd: assert property (!cmd.valid |=> !rsp.valid)
    else $error("answer without command");
  chk_code_unknown: assert property (cmd.valid && bad_code |=> !rsp.ack)
    else $error("unknown code accepted");
  chk_exp_range: assert property (fmt_wr && bad_exp |-> ##1 !rsp.ack)
    else $error("exponent out of range accepted");
  chk_format_ro: assert property (rsp.valid && !$past(cmd.write) &&
    $past(cmd.code) == `OVC_CODE_FORMAT |-> rsp.rdata[15:8] == 8'h00 && rsp.rdata[6:5] == 2'h0)
    else $error("format read shows mode bits");
  chk_enabled_lock: assert property (conversion_enable_pin [*4] ##0 fmt_wr |=> !rsp.ack)
    else $error("format write accepted while enabled");
  chk_warn_alert: assert property ($rose(status.limit_warn) |-> limit_alert)
    else $error("warning without alert");
  chk_warn_group: assert property (status.limit_warn |->
    status.word_vout && status.byte_none_above)
    else $error("warning without summary bits");
endmodule

// file: tb_ovc_regs.sv
`timescale 1ns/100ps
module tb_ovc_regs;
  logic sys_clk, rst_n, conv_en, pin_rst_n, restore, fault, sclr, alert;
  logic [7:0] bkup;
  logic [15:0] refv, step;
  ovc_pkg::ovc_cmd_s cmd;
  ovc_pkg::ovc_rsp_s rsp;
  ovc_pkg::ovc_misc_s misc;
  ovc_pkg::ovc_dflt_s dflt;
  ovc_pkg::ovc_limit_s lim;
  ovc_pkg::ovc_stat_s stat;
  int n_errors, cmp_count;
  ovc_host i_ovc_host (.sys_clk(sys_clk), .cmd(cmd), .rsp(rsp));
  ovc_regs i_ovc_regs (.sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp),
    .conversion_enable_pin(conv_en), .power_good_or_reset_pin_n(pin_rst_n),
    .miscellaneous_settings(misc), .defaults(dflt), .limits(lim),
    .transition_step(step), .restore_all(restore), .fault_restart(fault),
    .status_clear(sclr), .status(stat), .limit_alert(alert), .offset_backup(bkup),
    .reference(refv));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic a);
    i_ovc_host.xfer(1'b1, c, d);
    chk("ack", {15'h0, i_ovc_host.ack}, {15'h0, a});
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    i_ovc_host.xfer(1'b0, c, 16'h0);
    chk("rdata", i_ovc_host.rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic close_out;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    close_out;
  end
  initial begin
    {rst_n, conv_en, restore, fault, sclr, n_errors, cmp_count} = '0;
    pin_rst_n = 1;
    misc = 3'b001;
    // NVM format -12, target, offset backup, pin target; limits upper, lower
    dflt = {8'h14, 16'h1000, 8'h00, 16'h0800};
    lim = {16'h2000, 16'h0100};
    step = 16'h0100;
    cyc(4);
    rst_n = 1;
    cyc(2);
    rd(8'h20, 16'h0014);
    rd(8'h21, 16'h1000);
    rd(8'h22, 16'h0000);
    wr(8'h23, 16'h0000, 0);
    wr(8'h20, 16'h00f4, 1);
    rd(8'h20, 16'h0094);
    wr(8'h20, 16'h0014, 1);
    for (int i = 0; i < 3; i++) begin
      wr(8'h20, {11'h0, 5'h12 + 5'(i) * 5'h0b}, 0);
    end
    cyc(900);
    chk("reference", refv, 16'h1000);
    wr(8'h21, 16'h1800, 1);
    wr(8'h22, 16'h0100, 1);
    chk("ramping", {15'h0, refv < 16'h1900}, 16'h0001);
    cyc(1000);
    chk("reference", refv, 16'h1900);
    rd(8'h21, 16'h1800);
    wr(8'h21, 16'h3000, 1);
    cyc(2);
    chk("status", {13'h0, stat}, 16'h0007);
    chk("alert", {15'h0, alert}, 16'h0001);
    cyc(700);
    chk("reference", refv, 16'h2000);
    sclr = 1;
    cyc(1);
    sclr = 0;
    cyc(1);
    chk("cleared", {12'h0, stat, alert}, 16'h0000);
    wr(8'h22, 16'hff00, 1);
    cyc(2);
    chk("backup", {8'h0, bkup}, 16'h0080);
    wr(8'h22, 16'h0040, 1);
    cyc(2);
    chk("backup", {8'h0, bkup}, 16'h0040);
    pin_rst_n = 0;
    cyc(4);
    wr(8'h21, 16'h1200, 0);
    rd(8'h21, 16'h1000);
    pin_rst_n = 1;
    cyc(4);
    wr(8'h20, 16'h0018, 1);
    rd(8'h21, 16'h1000 >> 4);
    rd(8'h22, 16'h0040 >> 4);
    wr(8'h21, 16'h0120, 1);
    conv_en = 1;
    cyc(4);
    wr(8'h20, 16'h0014, 0);
    conv_en = 0;
    cyc(4);
    wr(8'h20, 16'h0014, 1);
    rd(8'h21, 16'h1200);
    fault = 1;
    cyc(1);
    fault = 0;
    cyc(2);
    rd(8'h21, 16'h1200);
    misc = 3'b011;
    fault = 1;
    cyc(1);
    fault = 0;
    cyc(2);
    rd(8'h21, 16'h1000);
    misc = 3'b101;
    restore = 1;
    cyc(1);
    restore = 0;
    cyc(2);
    rd(8'h21, 16'h0800);
    step = 16'h0000;
    wr(8'h21, 16'h0c00, 1);
    cyc(2);
    chk("reference", refv, 16'h0c00);
    wr(8'h21, 16'h0080, 1);
    cyc(2);
    chk("reference", refv, 16'h0100);
    close_out;
  end
endmodule
bind ovc_regs ovc_regs_asserts i_ovc_regs_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
  .cmd(cmd), .rsp(rsp), .conversion_enable_pin(conversion_enable_pin),
  .status(status), .limit_alert(limit_alert));
